// ===== pkg/hcb_map.svh
// Offsets, field positions, reset values and timing figures of the block.
`ifndef HCB_MAP_SVH
`define HCB_MAP_SVH

// ------------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------------
`define HCB_OFS_POWER_OC 8'h07
`define HCB_OFS_PORTMAP_IND 8'h08
`define HCB_OFS_FIXED_MASK 8'h09

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define HCB_BIT_AUTO_SWITCH 7
`define HCB_FLD_OC_HI 5
`define HCB_FLD_OC_LO 4
`define HCB_BIT_COMPOUND 3
`define HCB_BIT_RENUMBER 3
`define HCB_FLD_IND_HI 2
`define HCB_FLD_IND_LO 1
`define HCB_BIT_STRING 0
`define HCB_BIT_MASK_RSVD 0

// ------------------------------------------------------------------
// Write masks, reset values and the speed indicator code
// ------------------------------------------------------------------
`define HCB_WMASK_POWER_OC 8'hB8
`define HCB_WMASK_PORTMAP_IND 8'h0F
`define HCB_WMASK_FIXED 8'hFE
`define HCB_RST_BYTE 8'h00
`define HCB_IND_SPEED 2'b01

// ------------------------------------------------------------------
// Over-current filter delays in microseconds and the clock rate
// ------------------------------------------------------------------
`define HCB_CLK_MHZ 100
`define HCB_OC_DLY0_US 0.1e3
`define HCB_OC_DLY1_US 4000
`define HCB_OC_DLY2_US 8000
`define HCB_OC_DLY3_US 16000
`define HCB_OC_CYC(us) (int'((us) * `HCB_CLK_MHZ))

// Cycles for which ports and upstream stay dropped on a supply change.
`define HCB_DROP_HOLD 16

`endif

// ===== pkg/hcb_pkg.sv
// Types shared by the hub configuration block.
package hcb_pkg;

  typedef enum logic [0:0] {
    HCB_ATTACHED,
    HCB_DROPPED
  } hcb_power_state_t;

  typedef logic [20:0] hcb_oc_cycles_t;

endpackage : hcb_pkg

// ===== logic/hcb_power_switch.sv
// Automatic self/bus power switching with drop and re-attach sequence.
`timescale 1ns/1ps
`default_nettype none
`include "hcb_map.svh"

module hcb_power_switch
  import hcb_pkg::*;
#(
  parameter int HOLD_CYCLES = `HCB_DROP_HOLD
) (
  input wire logic ref_clk, // Core clock.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic autoSwitchEn, // Automatic switching enabled.
  input wire logic localSupplySense, // Local supply present.
  input wire logic cfgSelfPowered, // Configured self-powered bit.
  output logic selfPowered, // Hub runs self-powered.
  output logic portsOff, // Downstream power cut and disconnected.
  output logic upstreamOff // Upstream port disconnected.
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  hcb_power_state_t state_r, state_nxt;
  logic [15:0] holdCnt_r, holdCnt_nxt;
  logic senseLast_r, senseLast_nxt;
  logic self_r, self_nxt;
  logic off_r, off_nxt;
  logic supplyChange;

  assign supplyChange = autoSwitchEn && (localSupplySense != senseLast_r);

  always_comb begin
    state_nxt = state_r;
    holdCnt_nxt = holdCnt_r;
    senseLast_nxt = localSupplySense;
    self_nxt = self_r;
    case (state_r)
      HCB_ATTACHED: begin
        if (supplyChange) begin
          state_nxt = HCB_DROPPED;
          holdCnt_nxt = 16'(HOLD_CYCLES - 1);
        end else if (autoSwitchEn) begin
          self_nxt = localSupplySense;
        end else begin
          self_nxt = cfgSelfPowered;
        end
      end
      HCB_DROPPED: begin
        if (supplyChange) begin
          holdCnt_nxt = 16'(HOLD_CYCLES - 1);
        end else if (holdCnt_r == 16'h0000) begin
          state_nxt = HCB_ATTACHED;
          self_nxt = autoSwitchEn ? localSupplySense : cfgSelfPowered;
        end else begin
          holdCnt_nxt = holdCnt_r - 16'h0001;
        end
      end
      default: state_nxt = HCB_ATTACHED;
    endcase
    // The drop outputs are registered copies of the next state.
    off_nxt = (state_nxt == HCB_DROPPED);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= HCB_ATTACHED;
      holdCnt_r <= 16'h0000;
      senseLast_r <= 1'b0;
      self_r <= 1'b0;
      off_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      holdCnt_r <= holdCnt_nxt;
      senseLast_r <= senseLast_nxt;
      self_r <= self_nxt;
      off_r <= off_nxt;
    end
  end

  assign selfPowered = self_r;
  assign portsOff = off_r;
  assign upstreamOff = off_r;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_DROP_ON_CHANGE: assert property (@(posedge ref_clk) disable iff (reset)
    supplyChange |=> portsOff && upstreamOff)
    else $error("Supply change did not drop the ports.");

  AST_NO_DROP_WITHOUT_AUTO: assert property (@(posedge ref_clk) disable iff (reset)
    (!autoSwitchEn && !portsOff) |=> !portsOff)
    else $error("Ports dropped while automatic switching was off.");

  AST_REATTACH_MODE: assert property (@(posedge ref_clk) disable iff (reset)
    (portsOff && !supplyChange && holdCnt_r == 16'h0000 && autoSwitchEn)
      |=> !portsOff && selfPowered == $past(localSupplySense))
    else $error("Re-attach took the wrong power mode.");

endmodule // hcb_power_switch

`default_nettype wire

// ===== logic/hcb_config_regs.sv
// Hub configuration bytes for power, indicators and fixed-port devices.
//
// Overview of operation
// - Auto-switch bit enables local supply monitoring.
// - Supply change drops downstream and upstream at once.
// - Re-attach bus-powered or self-powered per supply.
// - Supply present with auto-switch means self-powered.
// - Two-bit field selects over-current filter delay.
// - Compound flag reports hub as compound device.
// - Strap mode: any fixed port implies compound.
// - Renumber bit selects standard or remap mode.
// - Indicator field: 01 speed, others standard.
// - Report indicator support only in standard mode.
// - String bit enables string descriptor support.
// - Mask bit n marks port n non-removable.
// - Mask bit zero always reads zero.
// - Default configuration takes fixed ports from straps.
// - Auto-switch ignores configured self-powered bit.
`timescale 1ns/1ps
`default_nettype none
`include "hcb_map.svh"

module hcb_config_regs
  import hcb_pkg::*;
#(
  parameter int OC_CYC0 = `HCB_OC_CYC(`HCB_OC_DLY0_US),
  parameter int OC_CYC1 = `HCB_OC_CYC(`HCB_OC_DLY1_US),
  parameter int OC_CYC2 = `HCB_OC_CYC(`HCB_OC_DLY2_US),
  parameter int OC_CYC3 = `HCB_OC_CYC(`HCB_OC_DLY3_US),
  parameter int DROP_HOLD_CYCLES = `HCB_DROP_HOLD
) (
  input wire logic ref_clk, // Core clock, 100 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic cfgWriteEn, // Loader writes a byte this cycle.
  input wire logic [7:0] cfgAddr, // Byte offset for write or read.
  input wire logic [7:0] cfgWriteData, // Byte to write.
  output logic [7:0] cfgReadData, // Byte at cfgAddr, one cycle later.
  input wire logic useStrapDefaults, // Internal default configuration.
  input wire logic [1:0] fixedPortStraps, // Fixed-port strap pins.
  input wire logic localSupplySense, // Local supply present.
  input wire logic cfgSelfPowered, // Configured self-powered bit.
  output logic selfPoweredMode, // Hub runs self-powered.
  output logic downstreamPowerOff, // All downstream ports dropped.
  output logic upstreamDisconnect, // Upstream port detached.
  output hcb_oc_cycles_t overcurrentFilterCycles, // Filter delay.
  output logic reportCompound, // Hub is part of a compound device.
  output logic portRenumberEnable, // Port remap mode.
  output logic speedIndicatorMode, // Indicators show link speed.
  output logic reportIndicatorSupport, // Indicators reported to host.
  output logic stringEnable, // String descriptors supported.
  output logic [7:0] fixedPortMask // Non-removable ports, bit n port n.
);

  // ------------------------------------------------------------------
  // Configuration bytes
  // ------------------------------------------------------------------
  logic [7:0] powerOc_r, powerOc_nxt;
  logic [7:0] portmapInd_r, portmapInd_nxt;
  logic [7:0] fixedMask_r, fixedMask_nxt;

  always_comb begin
    powerOc_nxt = powerOc_r;
    portmapInd_nxt = portmapInd_r;
    fixedMask_nxt = fixedMask_r;
    if (cfgWriteEn) begin
      case (cfgAddr)
        `HCB_OFS_POWER_OC:
          powerOc_nxt = cfgWriteData & `HCB_WMASK_POWER_OC;
        `HCB_OFS_PORTMAP_IND:
          portmapInd_nxt = cfgWriteData & `HCB_WMASK_PORTMAP_IND;
        `HCB_OFS_FIXED_MASK:
          fixedMask_nxt = cfgWriteData & `HCB_WMASK_FIXED;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      powerOc_r <= `HCB_RST_BYTE;
      portmapInd_r <= `HCB_RST_BYTE;
      fixedMask_r <= `HCB_RST_BYTE;
    end else begin
      powerOc_r <= powerOc_nxt;
      portmapInd_r <= portmapInd_nxt;
      fixedMask_r <= fixedMask_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Fixed-port mask source
  // ------------------------------------------------------------------
  // Two straps name up to three fixed ports counted up from port 1.
  logic [7:0] strapMask;
  logic [7:0] effMask;

  always_comb begin
    case (fixedPortStraps)
      2'b01: strapMask = 8'h02;
      2'b10: strapMask = 8'h06;
      2'b11: strapMask = 8'h0E;
      default: strapMask = 8'h00;
    endcase
  end

  assign effMask = useStrapDefaults ? strapMask : fixedMask_r;

  // ------------------------------------------------------------------
  // Decoded outputs
  // ------------------------------------------------------------------
  logic [1:0] indSel;
  logic [1:0] ocSel;
  logic compound_r, compound_nxt;
  logic renumber_r, renumber_nxt;
  logic speedInd_r, speedInd_nxt;
  logic indSupport_r, indSupport_nxt;
  logic string_r, string_nxt;
  logic [7:0] mask_r, mask_nxt;
  hcb_oc_cycles_t ocCyc_r, ocCyc_nxt;
  logic [7:0] rdData_r, rdData_nxt;

  assign indSel = portmapInd_r[`HCB_FLD_IND_HI:`HCB_FLD_IND_LO];
  assign ocSel = powerOc_r[`HCB_FLD_OC_HI:`HCB_FLD_OC_LO];

  always_comb begin
    if (useStrapDefaults) begin
      compound_nxt = |strapMask;
    end else begin
      compound_nxt = powerOc_r[`HCB_BIT_COMPOUND];
    end
    renumber_nxt = portmapInd_r[`HCB_BIT_RENUMBER];
    speedInd_nxt = (indSel == `HCB_IND_SPEED);
    indSupport_nxt = (indSel != `HCB_IND_SPEED);
    string_nxt = portmapInd_r[`HCB_BIT_STRING];
    mask_nxt = effMask;
    mask_nxt[`HCB_BIT_MASK_RSVD] = 1'b0;
    case (ocSel)
      2'b00: ocCyc_nxt = hcb_oc_cycles_t'(OC_CYC0);
      2'b01: ocCyc_nxt = hcb_oc_cycles_t'(OC_CYC1);
      2'b10: ocCyc_nxt = hcb_oc_cycles_t'(OC_CYC2);
      default: ocCyc_nxt = hcb_oc_cycles_t'(OC_CYC3);
    endcase
    case (cfgAddr)
      `HCB_OFS_POWER_OC: rdData_nxt = powerOc_r;
      `HCB_OFS_PORTMAP_IND: rdData_nxt = portmapInd_r;
      `HCB_OFS_FIXED_MASK: rdData_nxt = mask_nxt;
      default: rdData_nxt = `HCB_RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      compound_r <= 1'b0;
      renumber_r <= 1'b0;
      speedInd_r <= 1'b0;
      indSupport_r <= 1'b1;
      string_r <= 1'b0;
      mask_r <= `HCB_RST_BYTE;
      ocCyc_r <= hcb_oc_cycles_t'(OC_CYC0);
      rdData_r <= `HCB_RST_BYTE;
    end else begin
      compound_r <= compound_nxt;
      renumber_r <= renumber_nxt;
      speedInd_r <= speedInd_nxt;
      indSupport_r <= indSupport_nxt;
      string_r <= string_nxt;
      mask_r <= mask_nxt;
      ocCyc_r <= ocCyc_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign reportCompound = compound_r;
  assign portRenumberEnable = renumber_r;
  assign speedIndicatorMode = speedInd_r;
  assign reportIndicatorSupport = indSupport_r;
  assign stringEnable = string_r;
  assign fixedPortMask = mask_r;
  assign overcurrentFilterCycles = ocCyc_r;
  assign cfgReadData = rdData_r;

  // ------------------------------------------------------------------
  // Power switching
  // ------------------------------------------------------------------
  // The sub-block outputs are flip-flops, so they go straight out.
  hcb_power_switch #(
    .HOLD_CYCLES(DROP_HOLD_CYCLES)
  ) u_power (
    .ref_clk(ref_clk),
    .reset(reset),
    .autoSwitchEn(powerOc_r[`HCB_BIT_AUTO_SWITCH]),
    .localSupplySense(localSupplySense),
    .cfgSelfPowered(cfgSelfPowered),
    .selfPowered(selfPoweredMode),
    .portsOff(downstreamPowerOff),
    .upstreamOff(upstreamDisconnect)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_OC_DELAY: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (overcurrentFilterCycles == ($past(ocSel) == 2'b00 ? OC_CYC0 :
      $past(ocSel) == 2'b01 ? OC_CYC1 :
      $past(ocSel) == 2'b10 ? OC_CYC2 : OC_CYC3)))
    else $error("Over-current delay does not match its field.");

  AST_STRAP_COMPOUND: assert property (@(posedge ref_clk) disable iff (reset)
    (useStrapDefaults && fixedPortStraps != 2'b00) |=> reportCompound)
    else $error("Strapped fixed port did not report compound.");

  AST_COMPOUND_BIT: assert property (@(posedge ref_clk) disable iff (reset)
    !useStrapDefaults
      |=> reportCompound == $past(powerOc_r[`HCB_BIT_COMPOUND]))
    else $error("Compound report does not follow its flag.");

  AST_INDICATOR: assert property (@(posedge ref_clk) disable iff (reset)
    ##1 (reportIndicatorSupport != speedIndicatorMode))
    else $error("Indicator support reported in speed mode.");

  AST_SPEED_MODE: assert property (@(posedge ref_clk) disable iff (reset)
    (cfgWriteEn && cfgAddr == `HCB_OFS_PORTMAP_IND &&
      cfgWriteData[`HCB_FLD_IND_HI:`HCB_FLD_IND_LO] == `HCB_IND_SPEED)
      |=> ##1 speedIndicatorMode)
    else $error("Speed indication not selected by code 01.");

  AST_MASK_RSVD: assert property (@(posedge ref_clk) disable iff (reset)
    !fixedPortMask[`HCB_BIT_MASK_RSVD] &&
      ($past(cfgAddr) != `HCB_OFS_FIXED_MASK ||
      !cfgReadData[`HCB_BIT_MASK_RSVD]))
    else $error("Reserved mask bit reads as one.");

  AST_RSVD_READ: assert property (@(posedge ref_clk) disable iff (reset)
    ($past(cfgAddr) == `HCB_OFS_POWER_OC)
      |-> (cfgReadData & ~`HCB_WMASK_POWER_OC) == `HCB_RST_BYTE)
    else $error("Reserved bits of the power byte read non-zero.");

  AST_STRAP_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (useStrapDefaults && fixedPortStraps == 2'b11) |=> fixedPortMask == 8'h0E)
    else $error("Strapped fixed-port mask is wrong.");

  AST_STRING: assert property (@(posedge ref_clk) disable iff (reset)
    (cfgWriteEn && cfgAddr == `HCB_OFS_PORTMAP_IND)
      |=> ##1 stringEnable == $past(cfgWriteData[`HCB_BIT_STRING], 2))
    else $error("String enable does not follow its bit.");

endmodule // hcb_config_regs

`default_nettype wire

// ===== sim/hcb_loader_model.sv
// Behavioural configuration loader that writes and reads hub config bytes.
`timescale 1ns/1ps
`default_nettype none

module hcb_loader_model (
  input wire logic ref_clk, // Core clock.
  output logic cfgWriteEn, // Write strobe.
  output logic [7:0] cfgAddr, // Byte offset.
  output logic [7:0] cfgWriteData, // Byte to write.
  input wire logic [7:0] cfgReadData // Byte read back.
);
  initial begin
    cfgWriteEn = 1'b0;
    cfgAddr = 8'h00;
    cfgWriteData = 8'h00;
  end

  // One write per call; the strobe drops again once its edge has passed.
  task automatic writeByte(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cfgWriteEn = 1'b1;
    cfgAddr = a;
    cfgWriteData = d;
    @(negedge ref_clk);
    cfgWriteEn = 1'b0;
  endtask

  // Released data lines are inverted so a stale byte is never mistaken.
  task automatic readByte(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    cfgWriteEn = 1'b0;
    cfgAddr = a;
    cfgWriteData = ~cfgWriteData;
    repeat (2) @(negedge ref_clk);
    d = cfgReadData;
  endtask

  // The fixed ports are marked before the compound flag is raised.
  // No descriptor is loaded for them: the attached device brings its own.
  task automatic loadCompound(input logic [7:0] mask, input logic [7:0] b);
    writeByte(8'h09, mask);
    writeByte(8'h07, b | 8'h08);
  endtask
endmodule // hcb_loader_model

`default_nettype wire

// ===== sim/hub_config_bytes_power_led_nonremovable_bench.sv
// Self-checking bench for the hub configuration byte block.
`timescale 1ns/1ps
`default_nettype none
`include "hcb_map.svh"

module hub_config_bytes_power_led_nonremovable_bench
  import hcb_pkg::*;
;
  localparam int DROP = 4;
  logic ref_clk, reset, cfgWriteEn, useStrapDefaults;
  logic localSupplySense, cfgSelfPowered, selfPoweredMode;
  logic [7:0] cfgAddr, cfgWriteData, cfgReadData, fixedPortMask;
  logic [1:0] fixedPortStraps;
  logic downstreamPowerOff, upstreamDisconnect, reportCompound;
  logic portRenumberEnable, speedIndicatorMode, reportIndicatorSupport;
  logic stringEnable;
  hcb_oc_cycles_t overcurrentFilterCycles;
  logic [7:0] b07, b08, b09, rd;
  int mismatches, n_compared, seed, i, n;

  hcb_config_regs #(.OC_CYC0(10), .OC_CYC1(40), .OC_CYC2(80),
    .OC_CYC3(160), .DROP_HOLD_CYCLES(DROP)) i_hcb_config_regs (
    .ref_clk(ref_clk), .reset(reset), .cfgWriteEn(cfgWriteEn),
    .cfgAddr(cfgAddr), .cfgWriteData(cfgWriteData),
    .cfgReadData(cfgReadData), .useStrapDefaults(useStrapDefaults),
    .fixedPortStraps(fixedPortStraps),
    .localSupplySense(localSupplySense),
    .cfgSelfPowered(cfgSelfPowered), .selfPoweredMode(selfPoweredMode),
    .downstreamPowerOff(downstreamPowerOff),
    .upstreamDisconnect(upstreamDisconnect),
    .overcurrentFilterCycles(overcurrentFilterCycles),
    .reportCompound(reportCompound),
    .portRenumberEnable(portRenumberEnable),
    .speedIndicatorMode(speedIndicatorMode),
    .reportIndicatorSupport(reportIndicatorSupport),
    .stringEnable(stringEnable), .fixedPortMask(fixedPortMask));
  hcb_loader_model i_hcb_loader_model (.ref_clk(ref_clk),
    .cfgWriteEn(cfgWriteEn), .cfgAddr(cfgAddr),
    .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic hcb_oc_cycles_t expOc(input logic [1:0] f);
    case (f)
      2'b00: return 21'd10;
      2'b01: return 21'd40;
      2'b10: return 21'd80;
      default: return 21'd160;
    endcase
  endfunction

  function automatic logic [7:0] expMask();
    logic [7:0] s [4] = '{8'h00, 8'h02, 8'h06, 8'h0E};
    return useStrapDefaults ? s[fixedPortStraps] : (b09 & 8'hFE);
  endfunction

  function automatic logic expCompound();
    return useStrapDefaults ? (fixedPortStraps != 2'b00) : b07[3];
  endfunction

  task automatic cmp(input string nm, input logic [20:0] e,
      input logic [20:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic doWrite(input logic [7:0] a, input logic [7:0] d);
    i_hcb_loader_model.writeByte(a, d);
    if (a == `HCB_OFS_POWER_OC) b07 = d & `HCB_WMASK_POWER_OC;
    if (a == `HCB_OFS_PORTMAP_IND) b08 = d & `HCB_WMASK_PORTMAP_IND;
    if (a == `HCB_OFS_FIXED_MASK) b09 = d & `HCB_WMASK_FIXED;
  endtask

  task automatic checkAll();
    i_hcb_loader_model.readByte(8'h07, rd);
    cmp("byte07", 21'(b07), 21'(rd));
    i_hcb_loader_model.readByte(8'h08, rd);
    cmp("byte08", 21'(b08), 21'(rd));
    i_hcb_loader_model.readByte(8'h09, rd);
    cmp("byte09", 21'(expMask()), 21'(rd));
    i_hcb_loader_model.readByte(8'h0A, rd);
    cmp("unmapped", 21'd0, 21'(rd));
    cmp("ocCycles", expOc(b07[5:4]), overcurrentFilterCycles);
    cmp("compound", 21'(expCompound()), 21'(reportCompound));
    cmp("renumber", 21'(b08[3]), 21'(portRenumberEnable));
    cmp("speed", 21'(b08[2:1] == 2'b01), 21'(speedIndicatorMode));
    cmp("indSup", 21'(b08[2:1] != 2'b01), 21'(reportIndicatorSupport));
    cmp("string", 21'(b08[0]), 21'(stringEnable));
    cmp("mask", 21'(expMask()), 21'(fixedPortMask));
  endtask

  task automatic dropCheck(input logic expSelf);
    n = 0;
    while (downstreamPowerOff !== 1'b1 && n < 5) begin
      @(negedge ref_clk);
      n++;
    end
    cmp("dropSeen", 21'd1, 21'(downstreamPowerOff));
    cmp("upSeen", 21'd1, 21'(upstreamDisconnect));
    n = 0;
    while (downstreamPowerOff === 1'b1 && upstreamDisconnect === 1'b1
        && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    cmp("dropHold", 21'(DROP), 21'(n));
    cmp("upBack", 21'd0, 21'(upstreamDisconnect));
    cmp("selfPwr", 21'(expSelf), 21'(selfPoweredMode));
  endtask

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    mismatches++;
    finish_test();
  end

  initial begin
    seed = 72;
    mismatches = 0;
    n_compared = 0;
    reset = 1'b1;
    useStrapDefaults = 1'b0;
    fixedPortStraps = 2'b00;
    localSupplySense = 1'b0;
    cfgSelfPowered = 1'b0;
    {b07, b08, b09} = 24'h00_0000;
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    checkAll();
    // Every delay and indicator code, with reserved bits set.
    for (i = 0; i < 4; i++) begin
      doWrite(8'h07, 8'(i << 4) | 8'h47);
      doWrite(8'h08, 8'(i << 1) | 8'hF0);
      checkAll();
    end
    for (i = 0; i < 40; i++) begin
      if ({$random(seed)} % 4 == 0) doWrite(8'($random(seed)), 8'h5A);
      else doWrite(8'h07 + 8'({$random(seed)} % 3), 8'($random(seed)));
      if (i % 4 == 3) checkAll();
    end
    i_hcb_loader_model.loadCompound(8'h14, 8'h00);
    b09 = 8'h14;
    b07 = 8'h08;
    checkAll();
    doWrite(8'h07, 8'h00);
    b07 = 8'h00;
    useStrapDefaults = 1'b1;
    for (i = 0; i < 4; i++) begin
      fixedPortStraps = 2'(i);
      checkAll();
    end
    useStrapDefaults = 1'b0;
    cfgSelfPowered = 1'b1;
    localSupplySense = 1'b1;
    repeat (6) @(negedge ref_clk);
    cmp("noDrop", 21'd0, 21'(downstreamPowerOff));
    cmp("cfgSelf", 21'd1, 21'(selfPoweredMode));
    localSupplySense = 1'b0;
    cfgSelfPowered = 1'b0;
    doWrite(8'h07, 8'h80);
    repeat (4) @(negedge ref_clk);
    cmp("noDropOn", 21'd0, 21'(downstreamPowerOff));
    localSupplySense = 1'b1;
    dropCheck(1'b1);
    cfgSelfPowered = 1'b1;
    localSupplySense = 1'b0;
    dropCheck(1'b0);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    {b07, b08, b09} = 24'h00_0000;
    checkAll();
    finish_test();
  end
endmodule // hub_config_bytes_power_led_nonremovable_bench

`default_nettype wire
